// *** core/capture_fifo.sv ***
// Four-entry shift FIFO of capture values, oldest at index 0.
// Assumes the parent pushes when full only together with a pop; push and pop may coincide.
`timescale 1ns/1ps
`default_nettype none
module capture_fifo #(
  parameter int width = 16,
  parameter int depth = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic flush,
  input wire logic push,
  input wire logic [width-1:0] push_data,
  input wire logic pop,
  // Status
  output logic [width-1:0] head,
  output logic [$clog2(depth+1)-1:0] count
);
  logic [width-1:0] mem_r [depth];
  logic [$clog2(depth+1)-1:0] count_r;
  logic do_pop;
  logic do_push;
  logic [$clog2(depth+1)-1:0] wr_idx;

  // A pop of an empty FIFO is ignored; a push lands behind what survives the pop.
  assign do_pop = pop && (count_r != '0);
  assign do_push = push && (count_r != depth[$clog2(depth+1)-1:0] || do_pop);
  assign wr_idx = do_pop ? count_r - 1'b1 : count_r;

  // Entries below the last shift forward on a pop; each takes new data at the write index.
  for (genvar i = 0; i < depth; i++)
  begin : g_ent
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        mem_r[i] <= '0;
      else if (do_push && int'(wr_idx) == i)
        mem_r[i] <= push_data;
      else if (do_pop && i < depth - 1)
        mem_r[i] <= mem_r[(i < depth - 1) ? i + 1 : i];
    end
  end

  // Occupancy count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_r <= '0;
    else if (flush)
      count_r <= '0;
    else
      count_r <= count_r + (do_push ? 1'b1 : 1'b0) - (do_pop ? 1'b1 : 1'b0);
  end

  assign head = mem_r[0];
  assign count = count_r;
endmodule // capture_fifo
`default_nettype wire

// *** core/edge_timestamp_capture.sv ***
// One input capture channel with an APB register interface.
// Assumes the pin input, timebase counts and power states are synchronous to pclk.
// Summary of operation
// RL1 - Idle stop bit halts channel during idle
// RL2 - Timebase select: 1 first, 0 second counter
// RL3 - Events per interrupt field gives one to four
// RL4 - Overrun flag is read-only, shows overflow
// RL5 - Not-empty flag shows buffered data waiting
// RL6 - Modes 1,2,3: both, falling, rising edges
// RL7 - Modes 4,5: every fourth, sixteenth rise
// RL8 - Modes 0 and 6 are off
// RL9 - Mode 7: rising edge wakes only
// RL10 - Both-edge mode interrupts every event
// RL11 - Capture stores full 16-bit count
// RL12 - Software disables before changing mode
// RL13 - Event two cycles after pin edge
// RL14 - Four-deep FIFO, read oldest first
// RL15 - Unimplemented control bits read zero
// RL16 - Not-empty until all read; reads pop
// RL17 - Full capture dropped; overrun cleared by reads
// RL18 - Flags cleared on reset and disable
// RL19 - Overrun blocks interrupts unless one per event
// RL20 - Counters reset while channel disabled
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module edge_timestamp_capture #(
  parameter int count_width = 16,
  parameter int fifo_depth = 4
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Capture pin and timebases
  input wire logic capture_input_pin,
  input wire logic [count_width-1:0] first_timebase_count,
  input wire logic [count_width-1:0] second_timebase_count,
  // Event outputs
  output logic capture_irq,
  output logic wake_req
);
  logic [15:0] ctrl_r;
  logic [1:0] power_r;
  logic [1:0] pin_r;
  logic rise;
  logic fall;
  logic [3:0] pre_r;
  logic [1:0] epi_r;
  logic event_r;
  logic ovf_r;
  logic [2:0] ovf_reads_r;
  logic pop_cnt_pending;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic wake_r;
  logic [2:0] mode;
  logic idle_halt;
  logic enabled;
  logic trig;
  logic fifo_full;
  logic push;
  logic pop;
  logic setup;
  logic wr_ctrl;
  logic [count_width-1:0] head;
  logic [$clog2(fifo_depth+1)-1:0] count;
  logic [count_width-1:0] sel_count;
  logic epi_hit;

  assign mode = ctrl_r[edge_timestamp_capture_pkg::mode_lsb +: 3];
  assign idle_halt = ctrl_r[edge_timestamp_capture_pkg::idle_bit] &&
    power_r[edge_timestamp_capture_pkg::pwr_idle_bit]; // RL1
  assign enabled = (mode != edge_timestamp_capture_pkg::mode_off) &&
    (mode != edge_timestamp_capture_pkg::mode_unused) &&
    (mode != edge_timestamp_capture_pkg::mode_wake); // RL8
  assign setup = psel && !penable;
  assign wr_ctrl = setup && pwrite && paddr == edge_timestamp_capture_pkg::ctrl_addr;
  assign pop = setup && !pwrite && paddr == edge_timestamp_capture_pkg::fifo_addr; // RL16
  assign fifo_full = count == fifo_depth[$clog2(fifo_depth+1)-1:0];
  assign sel_count = ctrl_r[edge_timestamp_capture_pkg::tsel_bit] ?
    first_timebase_count : second_timebase_count; // RL2
  assign rise = pin_r[0] && !pin_r[1];
  assign fall = !pin_r[0] && pin_r[1];

  // Pin history: edge seen one cycle after the pin changes, event one cycle later.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_r <= 2'b00;
    else
      pin_r <= {pin_r[0], capture_input_pin};
  end

  // Edge qualification and prescaling per mode.
  always_comb
  begin
    trig = 1'b0;
    case (mode)
      edge_timestamp_capture_pkg::mode_both: trig = rise || fall; // RL6
      edge_timestamp_capture_pkg::mode_fall: trig = fall; // RL6
      edge_timestamp_capture_pkg::mode_rise: trig = rise; // RL6
      edge_timestamp_capture_pkg::mode_div4:
        trig = rise && pre_r == edge_timestamp_capture_pkg::div4_last; // RL7
      edge_timestamp_capture_pkg::mode_div16:
        trig = rise && pre_r == edge_timestamp_capture_pkg::div16_last; // RL7
      default: trig = 1'b0; // RL8 RL9
    endcase
    if (idle_halt)
      trig = 1'b0;
  end

  // Rising edge prescaler; restarts when the channel is off.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= 4'h0;
    else if (!enabled)
      pre_r <= 4'h0; // RL20
    else if (rise && !idle_halt &&
      (mode == edge_timestamp_capture_pkg::mode_div4 ||
      mode == edge_timestamp_capture_pkg::mode_div16))
      pre_r <= trig ? 4'h0 : pre_r + 4'h1;
  end

  // Registered event so the capture lands two cycles after the pin edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      event_r <= 1'b0;
    else
      event_r <= trig && enabled; // RL13
  end

  // A capture into a full FIFO is dropped unless a read frees a slot the same cycle.
  assign push = event_r && enabled && (!fifo_full || pop); // RL17

  capture_fifo #(
    .width(count_width),
    .depth(fifo_depth)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!enabled), // RL18
    .push(push), // RL11 RL14
    .push_data(sel_count),
    .pop(pop),
    .head(head),
    .count(count)
  );

  // Overrun flag; ones-per-event and both-edge settings never raise it.
  assign pop_cnt_pending = pop && count != '0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_r <= 1'b0;
      ovf_reads_r <= 3'h0;
    end
    else if (!enabled)
    begin
      ovf_r <= 1'b0; // RL18
      ovf_reads_r <= 3'h0;
    end
    else if (event_r && fifo_full && !pop &&
      mode != edge_timestamp_capture_pkg::mode_both &&
      ctrl_r[edge_timestamp_capture_pkg::epi_lsb +: 2] != 2'b00)
    begin
      ovf_r <= 1'b1; // RL17
      ovf_reads_r <= 3'h0;
    end
    else if (ovf_r && pop_cnt_pending)
    begin
      // The fourth read after the overrun clears it.
      if (ovf_reads_r + 3'h1 == edge_timestamp_capture_pkg::ovf_clear_reads)
      begin
        ovf_r <= 1'b0; // RL17
        ovf_reads_r <= 3'h0;
      end
      else
        ovf_reads_r <= ovf_reads_r + 3'h1;
    end
  end

  // Events per interrupt counter; both-edge mode fires on every event.
  assign epi_hit = (mode == edge_timestamp_capture_pkg::mode_both) ||
    epi_r == ctrl_r[edge_timestamp_capture_pkg::epi_lsb +: 2]; // RL3 RL10
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      epi_r <= 2'b00;
    else if (!enabled)
      epi_r <= 2'b00; // RL20
    else if (event_r)
      epi_r <= epi_hit ? 2'b00 : epi_r + 2'b01;
  end

  // Interrupt pulse; an overrun blocks it only when grouping events.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= enabled && event_r && epi_hit &&
        !(ovf_r && ctrl_r[edge_timestamp_capture_pkg::epi_lsb +: 2] != 2'b00); // RL19
  end

  // Wake-up pulse on a rising edge while asleep or idle in mode seven.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_r <= 1'b0;
    else
      wake_r <= mode == edge_timestamp_capture_pkg::mode_wake && rise &&
        (power_r != 2'b00); // RL9
  end

  // Control and power registers; status bits and unused bits are not stored.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= edge_timestamp_capture_pkg::ctrl_reset;
      power_r <= 2'b00;
    end
    else if (wr_ctrl)
      ctrl_r <= pwdata[15:0] & 16'h20e7; // RL15 RL4 RL5
    else if (setup && pwrite && paddr == edge_timestamp_capture_pkg::power_addr)
      power_r <= pwdata[1:0];
  end

  // APB answer: ready in the access cycle, zero wait states.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && paddr != edge_timestamp_capture_pkg::ctrl_addr &&
        paddr != edge_timestamp_capture_pkg::fifo_addr &&
        paddr != edge_timestamp_capture_pkg::power_addr;
      prdata_r <= 32'h0000_0000;
      if (setup && !pwrite)
        case (paddr)
          edge_timestamp_capture_pkg::ctrl_addr:
            prdata_r <= {16'h0000, ctrl_r[15:5], ovf_r, count != '0, ctrl_r[2:0]}; // RL5 RL4
          edge_timestamp_capture_pkg::fifo_addr:
            prdata_r <= {16'h0000, head}; // RL14
          edge_timestamp_capture_pkg::power_addr:
            prdata_r <= {30'h0, power_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign capture_irq = irq_r;
  assign wake_req = wake_r;

  // Assertions.
  property p_latency;
    @(posedge pclk) disable iff (!presetn)
      (mode == edge_timestamp_capture_pkg::mode_rise && $past(mode) == mode &&
      !idle_halt && rise && !fifo_full && !pop) |=> push;
  endproperty
  a_latency: assert property (p_latency) else $error("capture not two cycles after edge"); // RL13

  property p_off;
    @(posedge pclk) disable iff (!presetn) !enabled |=> !push && !irq_r;
  endproperty
  a_off: assert property (p_off) else $error("disabled channel captured"); // RL8

  property p_bne;
    @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == edge_timestamp_capture_pkg::ctrl_addr |=>
      prdata[edge_timestamp_capture_pkg::bne_bit] == ($past(count) != '0);
  endproperty
  a_bne: assert property (p_bne) else $error("not-empty flag read wrong"); // RL5

  property p_flush;
    @(posedge pclk) disable iff (!presetn) !enabled |=> count == '0 && !ovf_r;
  endproperty
  a_flush: assert property (p_flush) else $error("flags not cleared when off"); // RL18

  property p_noovf;
    @(posedge pclk) disable iff (!presetn)
      mode == edge_timestamp_capture_pkg::mode_both && $past(mode) == mode |-> !ovf_r;
  endproperty
  a_noovf: assert property (p_noovf) else $error("overrun in both-edge mode"); // RL17

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      mode == edge_timestamp_capture_pkg::mode_wake |=> !push;
  endproperty
  a_wake: assert property (p_wake) else $error("capture in wake mode"); // RL9

  property p_idle;
    @(posedge pclk) disable iff (!presetn) idle_halt |-> !trig;
  endproperty
  a_idle: assert property (p_idle) else $error("capture while idle halted"); // RL1

  property p_data;
    @(posedge pclk) disable iff (!presetn) push && count == '0 && !pop |=> head == $past(sel_count);
  endproperty
  a_data: assert property (p_data) else $error("wrong value captured"); // RL11

  // The edge is seen at the pin, the mode must hold one more cycle, then the event follows.
  sequence s_rise_at_pin;
    $rose(capture_input_pin) && mode == edge_timestamp_capture_pkg::mode_rise && !idle_halt;
  endsequence
  sequence s_rise_kept;
    mode == edge_timestamp_capture_pkg::mode_rise && !idle_halt;
  endsequence
  property p_rise_event;
    @(posedge pclk) disable iff (!presetn) s_rise_at_pin ##1 s_rise_kept |=> event_r;
  endproperty
  a_rise_event: assert property (p_rise_event) else $error("rising edge event late"); // RL13

  sequence s_fall_at_pin;
    $fell(capture_input_pin) && mode == edge_timestamp_capture_pkg::mode_fall && !idle_halt;
  endsequence
  sequence s_fall_kept;
    mode == edge_timestamp_capture_pkg::mode_fall && !idle_halt;
  endsequence
  property p_fall_event;
    @(posedge pclk) disable iff (!presetn) s_fall_at_pin ##1 s_fall_kept |=> event_r;
  endproperty
  a_fall_event: assert property (p_fall_event) else $error("falling edge event late"); // RL6

  property p_both_irq;
    @(posedge pclk) disable iff (!presetn)
      enabled && mode == edge_timestamp_capture_pkg::mode_both && event_r && !ovf_r |=> irq_r;
  endproperty
  a_both_irq: assert property (p_both_irq) else $error("both-edge event without irq"); // RL10

  property p_ovf_block;
    @(posedge pclk) disable iff (!presetn)
      ovf_r && ctrl_r[edge_timestamp_capture_pkg::epi_lsb +: 2] != 2'b00 |=> !irq_r;
  endproperty
  a_ovf_block: assert property (p_ovf_block) else $error("interrupt despite overrun"); // RL19

  property p_ovf_set;
    @(posedge pclk) disable iff (!presetn)
      enabled && event_r && fifo_full && !pop &&
      mode != edge_timestamp_capture_pkg::mode_both &&
      ctrl_r[edge_timestamp_capture_pkg::epi_lsb +: 2] != 2'b00 |=> ovf_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged"); // RL17
endmodule // edge_timestamp_capture
`default_nettype wire

// *** core/edge_timestamp_capture_pkg.sv ***
// Constants shared by the edge timestamp capture channel and its testbench.
// Assumes an APB slave with 32-bit data; registers sit in the low bits of each word.
package edge_timestamp_capture_pkg;
  // Register byte addresses.
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] fifo_addr = 12'h004;
  localparam logic [11:0] power_addr = 12'h008;
  // Control word field positions.
  localparam int mode_lsb = 0;
  localparam int bne_bit = 3;
  localparam int ovf_bit = 4;
  localparam int epi_lsb = 5;
  localparam int tsel_bit = 7;
  localparam int idle_bit = 13;
  // Power state register bits.
  localparam int pwr_idle_bit = 0;
  localparam int pwr_sleep_bit = 1;
  // Reset values.
  localparam logic [15:0] ctrl_reset = 16'h0000;
  // Mode encodings.
  localparam logic [2:0] mode_off = 3'h0;
  localparam logic [2:0] mode_both = 3'h1;
  localparam logic [2:0] mode_fall = 3'h2;
  localparam logic [2:0] mode_rise = 3'h3;
  localparam logic [2:0] mode_div4 = 3'h4;
  localparam logic [2:0] mode_div16 = 3'h5;
  localparam logic [2:0] mode_unused = 3'h6;
  localparam logic [2:0] mode_wake = 3'h7;
  // Prescale terminal counts (count minus one).
  localparam logic [3:0] div4_last = 4'h3;
  localparam logic [3:0] div16_last = 4'hf;
  // Reads needed to clear an overrun.
  localparam logic [2:0] ovf_clear_reads = 3'h4;
  // Timing: latency from pin edge to capture event, in pclk cycles.
  localparam int capture_latency_cycles = 2;
endpackage

// *** verification/pin_source.sv ***
// Partner model: the external signal on the capture input pin.
// Assumes one bench process calls set_level at a time.
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
  parameter int min_hold = 4
) (
  // Clock
  input wire logic pclk,
  // Pin
  output logic capture_input_pin
);
  initial capture_input_pin = 1'b0;
  // Waits out a minimum level time first, since short pulses are not legal input.
  task automatic set_level(input logic lvl);
    repeat (min_hold) @(posedge pclk);
    @(posedge pclk);
    capture_input_pin <= lvl;
  endtask
endmodule // pin_source
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the edge timestamp capture channel.
// Assumes an APB slave at pclk and a pin model that holds each level.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e); end end
module tb_top;
  localparam logic [11:0] a_ctl = edge_timestamp_capture_pkg::ctrl_addr;
  localparam logic [11:0] a_buf = edge_timestamp_capture_pkg::fifo_addr;
  localparam logic [11:0] a_pwr = edge_timestamp_capture_pkg::power_addr;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, irq, wake, er, pl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic [15:0] tb1, tb2;
  logic [15:0] q[$];
  int fails, check_count, cyc, irq_n, wake_n, irq_at;
  int mode, epi, tsel, ist, ovf, pc, ec, rc, exp_irq, exp_wake, idle, sleep;
  int ovm[3] = '{3, 1, 3};
  int ove[3] = '{1, 1, 0};
  edge_timestamp_capture i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_pin(pin),
    .first_timebase_count(tb1), .second_timebase_count(tb2), .capture_irq(irq),
    .wake_req(wake));
  pin_source i_pin (.pclk(pclk), .capture_input_pin(pin));
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;
  // Counts cycles and event pulses; pulses last one cycle so each edge sees each once.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (irq === 1'b1) irq_at <= cyc;
    if (wake === 1'b1) wake_n <= wake_n + 1;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; the request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      fails++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_ctrl();
    int bne;
    bne = q.size() != 0;
    apb(0, a_ctl, 32'h0);
    `CHK(rd, 32'(ist << 13 | tsel << 7 | epi << 5 | ovf << 4 | bne << 3 | mode), "ctrl")
    `CHK(irq_n, exp_irq, "irq count")
    `CHK(wake_n, exp_wake, "wake count")
  endtask
  task automatic drain(input int n);
    logic [15:0] v;
    repeat (n)
    begin
      apb(0, a_buf, 32'h0);
      v = q.pop_front();
      `CHK(rd, {16'h0, v}, "fifo head")
      rc++;
      if (ovf && rc == 4) ovf = 0;
    end
    chk_ctrl();
  endtask
  task automatic pwr(input int i, input int s);
    idle = i;
    sleep = s;
    apb(1, a_pwr, 32'(s << 1 | i));
  endtask
  // Disables first, so flags and counters are seen cleared between modes.
  task automatic cfg(input int m, input int e, input int t, input int s);
    mode = 0;
    epi = 0;
    tsel = 0;
    ist = 0;
    ovf = 0;
    pc = 0;
    ec = 0;
    q.delete();
    apb(1, a_ctl, 32'h0);
    chk_ctrl();
    mode = m;
    epi = e;
    tsel = t;
    ist = s;
    apb(1, a_ctl, 32'(s << 13 | t << 7 | e << 5 | m));
  endtask
  // One pin transition with fresh counts, mirrored in the model.
  task automatic step(input logic lvl, input bit ad);
    bit r, f, ev, gi, ov0;
    int t0;
    r = lvl & ~pl;
    f = ~lvl & pl;
    pl = lvl;
    ev = 0;
    gi = 0;
    lfsr = nxt(lfsr);
    tb1 <= lfsr[15:0];
    tb2 <= lfsr[31:16];
    i_pin.set_level(lvl);
    t0 = cyc;
    if (!(ist && idle))
      case (mode)
        1: ev = 1;
        2: ev = f;
        3: ev = r;
        4, 5:
        begin
          pc += r;
          ev = pc == (mode == 4 ? 4 : 16);
          if (ev) pc = 0;
        end
        default: ev = 0;
      endcase
    if (mode == 7 && r && (idle || sleep)) exp_wake++;
    if (ev)
    begin
      ov0 = ovf;
      if (q.size() < 4) q.push_back(tsel ? tb1 : tb2);
      else if (epi != 0 && mode != 1)
      begin
        ovf = 1;
        rc = 0;
      end
      ec++;
      if (mode == 1 || ec == epi + 1)
      begin
        ec = 0;
        gi = !(ov0 && epi != 0 && mode != 1);
        exp_irq += gi;
      end
    end
    repeat (8) @(posedge pclk);
    if (gi) `CHK(irq_at - t0, 2 + edge_timestamp_capture_pkg::capture_latency_cycles, "lat")
    chk_ctrl();
    if (ad && q.size() == 4) drain(4);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tb1, tb2, pl} = '0;
    {fails, check_count, cyc, irq_n, wake_n, irq_at, mode, epi, tsel, ist} = '0;
    {ovf, pc, ec, rc, exp_irq, exp_wake, idle, sleep} = '0;
    lfsr = 32'hf4688ac2;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_ctrl();
    apb(1, a_ctl, 32'hfffffff8);
    apb(0, a_ctl, 32'h0);
    `CHK(rd, 32'h000020e0, "ctrl mask")
    apb(0, 12'h010, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0}, "unmapped")
    $display("Test registers done");
    for (int m = 0; m < 7; m++)
    begin
      lfsr = nxt(lfsr);
      cfg(m, m % 4, lfsr[7], 0);
      repeat (36) step(~pl, 1);
      drain(q.size());
      $display("Test mode %0d done", m);
    end
    foreach (ovm[i])
    begin
      cfg(ovm[i], ove[i], 1, 0);
      repeat (10) step(~pl, 0);
      drain(4);
    end
    repeat (4) step(~pl, 0);
    cfg(7, 0, 0, 0);
    $display("Test overflow done");
    pwr(0, 1);
    repeat (4) step(~pl, 0);
    pwr(1, 0);
    repeat (4) step(~pl, 0);
    pwr(0, 0);
    repeat (4) step(~pl, 0);
    pwr(1, 0);
    cfg(3, 0, 1, 1);
    repeat (4) step(~pl, 0);
    cfg(3, 0, 0, 0);
    repeat (4) step(~pl, 0);
    drain(q.size());
    pwr(0, 0);
    $display("Test power done");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
